// ===== module_ext_pkg.sv
// Summary of operation
// - Equalization codes 0-10 give 0-10 dB; code 11 and codes 12-15 are reserved.
// - Emphasis codes 0-7 give 0-7 dB; any code with the top bit set is vendor specific.
// - The upper nibble applies at high rate and the lower nibble at low rate.
// - Bit 4 of the extended control byte reports transmit adaptive equalization failure.
// - The soft transmit rate bit is read/write, ORed with its pin, and powers up low except in retimer configuration.
// - The soft receive rate bit at byte 110 bit 3 is read/write and ORed with its pin.
// - Bit 2 enables the highest power level only when that level is advertised.
// - The power state bit reads 0 at the lowest level and 1 at any higher level.
// - At the highest level the state bit sets only once circuits and laser are steady.
// - Power select bit 0 permits intermediate levels and is ignored when not implemented.
// - The 64G bit overrides all rate selections and powers up low.
// - Bits 4 and 3 report transmit and receive configured for the four-level rate.
// - The transmit lock flag is 1 on loss of lock and 0 when locked or bypassed.
// - The receive lock flag uses the same encoding for the receive clock recovery.
// - In retimer configuration both soft rate bits default to 1 and steer the retimers.
// - Retimer modes follow the four-row table of the two combined rate selections.
// - The page register holds 00h after startup.
// - Bytes 128-247 are accessed in the page selected by the page register.
// - An unsupported page write is rejected and the page register reverts to 0.
// - On page 00h bytes 128-247 are 120 bytes of host-writable storage.
// - Page 01h aliases the page 00h storage.
// - Bytes 120-126 and 248-255 are vendor-specific storage.
package module_ext_pkg;
	localparam logic [7:0] OFS_RX_RATE = 8'h6E;
	localparam logic [7:0] OFS_EQ = 8'h72;
	localparam logic [7:0] OFS_EMPH = 8'h73;
	localparam logic [7:0] OFS_EXT = 8'h76;
	localparam logic [7:0] OFS_EXT2 = 8'h77;
	localparam logic [7:0] OFS_VMEM_LO = 8'h78;
	localparam logic [7:0] OFS_VMEM_HI = 8'h7E;
	localparam logic [7:0] OFS_PAGE = 8'h7F;
	localparam logic [7:0] OFS_USER_LO = 8'h80;
	localparam logic [7:0] OFS_USER_HI = 8'hF7;
	localparam logic [7:0] OFS_VCTRL_LO = 8'hF8;
	localparam int RX_SW_RATE_BIT = 3;
	localparam int EXT_ADAPT_FAIL_BIT = 4;
	localparam int EXT_SW_TX_RATE_BIT = 3;
	localparam int EXT_PL4_EN_BIT = 2;
	localparam int EXT_PL_STATE_BIT = 1;
	localparam int EXT_PL_SEL_BIT = 0;
	localparam int EXT2_TX_READY_BIT = 4;
	localparam int EXT2_RX_READY_BIT = 3;
	localparam int EXT2_FC64_BIT = 2;
	localparam int EXT2_TX_LOCK_BIT = 1;
	localparam int EXT2_RX_LOCK_BIT = 0;
	localparam int EMPH_VENDOR_BIT = 3;
	localparam logic [3:0] EQ_MAX_CODE = 4'hA;
	localparam logic [7:0] ID_RETIMER = 8'h0E;
	localparam logic [7:0] PAGE_USER0 = 8'h00;
	localparam logic [7:0] PAGE_USER1 = 8'h01;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam int USER_BYTES = 120;
	localparam int VMEM_BYTES = 7;
	localparam int VCTRL_BYTES = 8;
	localparam int PIN_COUNT = 3;
	typedef enum logic [1:0] {CDR_LOCK_LOW, CDR_LOCK_HIGH, CDR_BYPASS} cdr_mode_t;
endpackage

// ===== module_ext_ctrl_and_paging.sv
`timescale 1ns/10ps
module module_ext_ctrl_and_paging (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic tx_rate_line_i,
	input wire logic rx_rate_line_i,
	input wire logic laser_off_input_i,
	input wire logic [7:0] ident_byte_i,
	input wire logic cdr_present_i,
	input wire logic level4_advertised_i,
	input wire logic mid_levels_impl_i,
	input wire logic circuits_steady_i,
	input wire logic laser_temp_stable_i,
	input wire logic optical_present_i,
	input wire logic tx_adapt_fail_i,
	input wire logic tx_fourlevel_ready_i,
	input wire logic rx_fourlevel_ready_i,
	input wire logic tx_lock_lost_i,
	input wire logic rx_lock_lost_i,
	output logic [3:0] tx_eq_db_o,
	output logic tx_eq_code_bad_o,
	output logic [2:0] rx_emph_db_o,
	output logic rx_emph_vendor_o,
	output logic tx_rate_full_o,
	output logic rx_rate_full_o,
	output logic fc64_speed_mode_o,
	output module_ext_pkg::cdr_mode_t tx_cdr_mode_o,
	output module_ext_pkg::cdr_mode_t rx_cdr_mode_o,
	output logic pl_high_enable_o,
	output logic pl_mid_enable_o
);
	import module_ext_pkg::*;

	logic [PIN_COUNT-1:0] pin_raw;
	logic [PIN_COUNT-1:0] pin_s1;
	logic [PIN_COUNT-1:0] pin_s2;
	logic [PIN_COUNT-1:0] pin_s3;
	logic [PIN_COUNT-1:0] pin_f;
	logic init_done;
	logic [7:0] eq_reg;
	logic [7:0] emph_reg;
	logic sw_tx_rate;
	logic sw_rx_rate;
	logic pl4_en;
	logic pl_sel;
	logic pl_state;
	logic fc64;
	logic [7:0] page;
	logic [7:0] user_mem [USER_BYTES];
	logic [7:0] vmem [VMEM_BYTES];
	logic [7:0] vctrl [VCTRL_BYTES];
	logic retimer_cfg;
	logic tx_eff;
	logic rx_eff;
	logic tx_bypass;
	logic rx_bypass;
	logic [7:0] ext_byte;
	logic [7:0] ext2_byte;
	logic [7:0] next_rdata;
	logic [3:0] next_eq;
	logic [3:0] next_emph;
	logic wr_user;
	logic wr_vmem;
	logic wr_vctrl;
	logic page_ok;

	assign pin_raw = {laser_off_input_i, rx_rate_line_i, tx_rate_line_i};

	// Three stages; a level is accepted only once the last two stages agree.
	for (genvar g = 0; g < PIN_COUNT; g++) begin : g_pin_sync
		always_ff @(posedge clk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				pin_s1[g] <= 1'b0;
				pin_s2[g] <= 1'b0;
				pin_s3[g] <= 1'b0;
				pin_f[g] <= 1'b0;
			end else begin
				pin_s1[g] <= pin_raw[g];
				pin_s2[g] <= pin_s1[g];
				pin_s3[g] <= pin_s2[g];
				if (pin_s2[g] == pin_s3[g]) begin
					pin_f[g] <= pin_s3[g];
				end
			end
		end
	end

	assign retimer_cfg = (ident_byte_i == ID_RETIMER) && cdr_present_i;
	assign tx_eff = pin_f[0] | sw_tx_rate;
	assign rx_eff = pin_f[1] | sw_rx_rate;
	assign tx_bypass = (tx_cdr_mode_o == CDR_BYPASS);
	assign rx_bypass = (rx_cdr_mode_o == CDR_BYPASS);
	assign wr_user = wr_i && addr_i >= OFS_USER_LO && addr_i <= OFS_USER_HI;
	assign wr_vmem = wr_i && addr_i >= OFS_VMEM_LO && addr_i <= OFS_VMEM_HI;
	assign wr_vctrl = wr_i && addr_i >= OFS_VCTRL_LO;
	assign page_ok = (wdata_i == PAGE_USER0) || (wdata_i == PAGE_USER1);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			init_done <= 1'b0;
		end else begin
			init_done <= 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			eq_reg <= RST_BYTE;
			emph_reg <= RST_BYTE;
		end else if (wr_i && addr_i == OFS_EQ) begin
			eq_reg <= wdata_i;
		end else if (wr_i && addr_i == OFS_EMPH) begin
			emph_reg <= wdata_i;
		end
	end

	// The retimer strap is caught on the first edge after release, never by the reset itself.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sw_tx_rate <= 1'b0;
			sw_rx_rate <= 1'b0;
		end else if (!init_done) begin
			sw_tx_rate <= retimer_cfg;
			sw_rx_rate <= retimer_cfg;
		end else if (wr_i && addr_i == OFS_EXT) begin
			sw_tx_rate <= wdata_i[EXT_SW_TX_RATE_BIT];
		end else if (wr_i && addr_i == OFS_RX_RATE) begin
			sw_rx_rate <= wdata_i[RX_SW_RATE_BIT];
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pl4_en <= 1'b0;
			pl_sel <= 1'b0;
		end else if (wr_i && addr_i == OFS_EXT) begin
			pl4_en <= wdata_i[EXT_PL4_EN_BIT] & level4_advertised_i;
			pl_sel <= wdata_i[EXT_PL_SEL_BIT] & mid_levels_impl_i;
		end
	end

	// At the highest level the bit waits for thermal and optical settling.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pl_state <= 1'b0;
		end else if (pl4_en) begin
			pl_state <= circuits_steady_i && laser_temp_stable_i
				&& (pin_f[2] || optical_present_i);
		end else begin
			pl_state <= pl_sel;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fc64 <= 1'b0;
		end else if (wr_i && addr_i == OFS_EXT2) begin
			fc64 <= wdata_i[EXT2_FC64_BIT];
		end
	end

	// Only the two user pages exist here, so anything else falls back to page 00h.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			page <= PAGE_USER0;
		end else if (wr_i && addr_i == OFS_PAGE) begin
			page <= page_ok ? wdata_i : PAGE_USER0;
		end
	end

	// Storage is volatile flip-flops; contents do not survive a reset or power loss.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < USER_BYTES; i++) begin
				user_mem[i] <= RST_BYTE;
			end
		end else if (wr_user) begin
			user_mem[addr_i[6:0]] <= wdata_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < VMEM_BYTES; i++) begin
				vmem[i] <= RST_BYTE;
			end
			for (int i = 0; i < VCTRL_BYTES; i++) begin
				vctrl[i] <= RST_BYTE;
			end
		end else if (wr_vmem) begin
			vmem[addr_i[2:0]] <= wdata_i;
		end else if (wr_vctrl) begin
			vctrl[addr_i[2:0]] <= wdata_i;
		end
	end

	always_comb begin
		ext_byte = RST_BYTE;
		ext_byte[EXT_ADAPT_FAIL_BIT] = tx_adapt_fail_i;
		ext_byte[EXT_SW_TX_RATE_BIT] = sw_tx_rate;
		ext_byte[EXT_PL4_EN_BIT] = pl4_en;
		ext_byte[EXT_PL_STATE_BIT] = pl_state;
		ext_byte[EXT_PL_SEL_BIT] = pl_sel;
		ext2_byte = RST_BYTE;
		ext2_byte[EXT2_TX_READY_BIT] = tx_fourlevel_ready_i;
		ext2_byte[EXT2_RX_READY_BIT] = rx_fourlevel_ready_i;
		ext2_byte[EXT2_FC64_BIT] = fc64;
		ext2_byte[EXT2_TX_LOCK_BIT] = tx_lock_lost_i & ~tx_bypass;
		ext2_byte[EXT2_RX_LOCK_BIT] = rx_lock_lost_i & ~rx_bypass;
	end

	always_comb begin
		next_rdata = RST_BYTE;
		if (rd_i) begin
			if (addr_i >= OFS_USER_LO && addr_i <= OFS_USER_HI) begin
				next_rdata = user_mem[addr_i[6:0]];
			end else if (addr_i >= OFS_VCTRL_LO) begin
				next_rdata = vctrl[addr_i[2:0]];
			end else if (addr_i >= OFS_VMEM_LO && addr_i <= OFS_VMEM_HI) begin
				next_rdata = vmem[addr_i[2:0]];
			end else begin
				unique case (addr_i)
					OFS_RX_RATE: next_rdata[RX_SW_RATE_BIT] = sw_rx_rate;
					OFS_EQ: next_rdata = eq_reg;
					OFS_EMPH: next_rdata = emph_reg;
					OFS_EXT: next_rdata = ext_byte;
					OFS_EXT2: next_rdata = ext2_byte;
					OFS_PAGE: next_rdata = page;
					default: next_rdata = RST_BYTE;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_o <= RST_BYTE;
		end else begin
			rdata_o <= next_rdata;
		end
	end

	// Nibble choice follows the combined rate; the 64G mode forces the low nibble.
	always_comb begin
		next_eq = (tx_eff && !fc64) ? eq_reg[7:4] : eq_reg[3:0];
		next_emph = (rx_eff && !fc64) ? emph_reg[7:4] : emph_reg[3:0];
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_eq_db_o <= 4'h0;
			tx_eq_code_bad_o <= 1'b0;
			rx_emph_db_o <= 3'h0;
			rx_emph_vendor_o <= 1'b0;
		end else begin
			tx_eq_code_bad_o <= next_eq > EQ_MAX_CODE;
			tx_eq_db_o <= (next_eq > EQ_MAX_CODE) ? 4'h0 : next_eq;
			rx_emph_vendor_o <= next_emph[EMPH_VENDOR_BIT];
			rx_emph_db_o <= next_emph[EMPH_VENDOR_BIT] ? 3'h0 : next_emph[2:0];
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_rate_full_o <= 1'b0;
			rx_rate_full_o <= 1'b0;
			fc64_speed_mode_o <= 1'b0;
			pl_high_enable_o <= 1'b0;
			pl_mid_enable_o <= 1'b0;
		end else begin
			tx_rate_full_o <= tx_eff && !fc64;
			rx_rate_full_o <= rx_eff && !fc64;
			fc64_speed_mode_o <= fc64;
			pl_high_enable_o <= pl4_en;
			pl_mid_enable_o <= pl_sel;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_cdr_mode_o <= CDR_LOCK_LOW;
			rx_cdr_mode_o <= CDR_LOCK_LOW;
		end else if (fc64) begin
			tx_cdr_mode_o <= CDR_LOCK_HIGH;
			rx_cdr_mode_o <= CDR_LOCK_HIGH;
		end else if (retimer_cfg) begin
			unique case ({rx_eff, tx_eff})
				2'b00: begin
					rx_cdr_mode_o <= CDR_LOCK_LOW;
					tx_cdr_mode_o <= CDR_LOCK_LOW;
				end
				2'b01: begin
					rx_cdr_mode_o <= CDR_LOCK_HIGH;
					tx_cdr_mode_o <= CDR_BYPASS;
				end
				2'b10: begin
					rx_cdr_mode_o <= CDR_BYPASS;
					tx_cdr_mode_o <= CDR_BYPASS;
				end
				2'b11: begin
					rx_cdr_mode_o <= CDR_LOCK_HIGH;
					tx_cdr_mode_o <= CDR_LOCK_HIGH;
				end
			endcase
		end else begin
			rx_cdr_mode_o <= rx_eff ? CDR_LOCK_HIGH : CDR_LOCK_LOW;
			tx_cdr_mode_o <= tx_eff ? CDR_LOCK_HIGH : CDR_LOCK_LOW;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	property p_eq_decode;
		tx_eq_code_bad_o |-> tx_eq_db_o == 4'h0;
	endproperty
	a_eq_decode: assert property (p_eq_decode) else $error("reserved eq code drives a level");

	property p_emph_vendor;
		rx_emph_vendor_o |-> rx_emph_db_o == 3'h0;
	endproperty
	a_emph_vendor: assert property (p_emph_vendor) else $error("vendor emphasis code drives a level");

	property p_eq_nibble;
		(tx_eff && !fc64 && eq_reg[7:4] <= EQ_MAX_CODE) |=> tx_eq_db_o == $past(eq_reg[7:4]);
	endproperty
	a_eq_nibble: assert property (p_eq_nibble) else $error("high rate did not use upper nibble");

	property p_pl4_gate;
		(wr_i && addr_i == OFS_EXT && !level4_advertised_i) |=> ##1 !pl_high_enable_o;
	endproperty
	a_pl4_gate: assert property (p_pl4_gate) else $error("unadvertised level enabled");

	property p_pl_steady;
		(pl4_en && !laser_temp_stable_i) |=> !pl_state;
	endproperty
	a_pl_steady: assert property (p_pl_steady) else $error("power state set before laser stable");

	property p_fc64_override;
		fc64 |=> !tx_rate_full_o && !rx_rate_full_o && fc64_speed_mode_o;
	endproperty
	a_fc64_override: assert property (p_fc64_override) else $error("rate selection not ignored");

	property p_lock_bypass;
		(rd_i && addr_i == OFS_EXT2 && tx_bypass) |=> !rdata_o[EXT2_TX_LOCK_BIT];
	endproperty
	a_lock_bypass: assert property (p_lock_bypass) else $error("bypassed lock flag not zero");

	property p_retimer_tx_only;
		(init_done && retimer_cfg && !fc64 && tx_eff && !rx_eff) |=>
			tx_cdr_mode_o == CDR_BYPASS && rx_cdr_mode_o == CDR_LOCK_HIGH;
	endproperty
	a_retimer_tx_only: assert property (p_retimer_tx_only) else $error("retimer table row wrong");

	property p_page_reject;
		(wr_i && addr_i == OFS_PAGE && !page_ok) |=> page == PAGE_USER0;
	endproperty
	a_page_reject: assert property (p_page_reject) else $error("bad page accepted");

	property p_read_latency;
		(rd_i && addr_i == OFS_EQ) |=> rdata_o == $past(eq_reg) ##1 ($past(rd_i) || rdata_o == 8'h00);
	endproperty
	a_read_latency: assert property (p_read_latency) else $error("read data not one cycle later");

	property p_reserved_zero;
		(rd_i && (addr_i == OFS_EXT || addr_i == OFS_EXT2)) |=> rdata_o[7:5] == 3'h0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero");

	c_page_reject: cover property (wr_i && addr_i == OFS_PAGE && !page_ok ##1 page == PAGE_USER0);
	c_fc64_on: cover property (wr_i && addr_i == OFS_EXT2 && wdata_i[EXT2_FC64_BIT]);
	c_user_rw: cover property (wr_user ##1 rd_i && addr_i >= OFS_USER_LO);
	c_retimer_bypass: cover property (retimer_cfg && rx_bypass);
endmodule

// ===== module_ext_ctrl_and_paging_note_end.sv
// This file holds no logic; the whole block is one module.

// ===== module_ext_host_model.sv
`timescale 1ns/10ps
module module_ext_host_model (
	input wire logic clk_i,
	output logic [7:0] addr_o,
	output logic [7:0] wdata_o,
	output logic wr_o,
	output logic rd_o,
	input wire logic [7:0] rdata_i
);
	initial begin
		addr_o = 8'h00;
		wdata_o = 8'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	// Storage bytes are written one at a time and only a few, never as a stream.
	task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
		wdata_o <= ~d;
	endtask
	// Read data stand only in the cycle after the strobe, so they are taken just after that edge.
	task automatic read_byte(input logic [7:0] a, output logic [7:0] q);
		@(posedge clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		#1;
		q = rdata_i;
	endtask
endmodule

// ===== module_ext_ctrl_and_paging_test.sv
`timescale 1ns/10ps
module module_ext_ctrl_and_paging_test;
	import module_ext_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic bus_wr;
	logic bus_rd;
	logic tx_line = 1'b0, rx_line = 1'b0, laser_off = 1'b0, cdr_present = 1'b0;
	logic level4_adv = 1'b0, mid_impl = 1'b0, steady = 1'b0, temp_ok = 1'b0, optical = 1'b0;
	logic adapt_fail = 1'b0, tx_ready = 1'b0, rx_ready = 1'b0, tx_lost = 1'b0, rx_lost = 1'b0;
	logic [7:0] ident = 8'h00;
	logic [3:0] eq_db;
	logic [2:0] emph_db;
	logic eq_bad, emph_vendor, tx_full, rx_full, fc64, pl_high, pl_mid;
	cdr_mode_t tx_mode, rx_mode;
	cdr_mode_t rx_tab [4];
	cdr_mode_t tx_tab [4];
	logic [7:0] bad_pages [6];
	int err_count = 0;
	int comparisons = 0;

	always #10 clk = ~clk;

	module_ext_host_model module_ext_host_model_inst (.clk_i(clk), .addr_o(addr),
		.wdata_o(wdata), .wr_o(bus_wr), .rd_o(bus_rd), .rdata_i(rdata));

	module_ext_ctrl_and_paging module_ext_ctrl_and_paging_inst (.clk_i(clk), .rst_n_i(rst_n),
		.addr_i(addr), .wdata_i(wdata), .wr_i(bus_wr), .rd_i(bus_rd), .rdata_o(rdata),
		.tx_rate_line_i(tx_line), .rx_rate_line_i(rx_line), .laser_off_input_i(laser_off),
		.ident_byte_i(ident), .cdr_present_i(cdr_present), .level4_advertised_i(level4_adv),
		.mid_levels_impl_i(mid_impl), .circuits_steady_i(steady), .laser_temp_stable_i(temp_ok),
		.optical_present_i(optical), .tx_adapt_fail_i(adapt_fail),
		.tx_fourlevel_ready_i(tx_ready), .rx_fourlevel_ready_i(rx_ready),
		.tx_lock_lost_i(tx_lost), .rx_lock_lost_i(rx_lost), .tx_eq_db_o(eq_db),
		.tx_eq_code_bad_o(eq_bad), .rx_emph_db_o(emph_db), .rx_emph_vendor_o(emph_vendor),
		.tx_rate_full_o(tx_full), .rx_rate_full_o(rx_full), .fc64_speed_mode_o(fc64),
		.tx_cdr_mode_o(tx_mode), .rx_cdr_mode_o(rx_mode), .pl_high_enable_o(pl_high),
		.pl_mid_enable_o(pl_mid));

	task automatic test_done();
		$display("comparisons %0d err_count %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons = comparisons + 1;
		if (seen !== exp) begin
			err_count = err_count + 1;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic put_byte(input logic [7:0] a, input logic [7:0] d);
		module_ext_host_model_inst.write_byte(a, d);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] v;
		module_ext_host_model_inst.read_byte(a, v);
		check(v, exp);
	endtask

	// Outputs pass one registered stage and pins a synchronizer, so callers wait 3 cycles after a register write and 8 after a pin change.
	task automatic wait_out(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		err_count = err_count + 1;
		test_done();
	end

	initial begin
		rx_tab = '{CDR_LOCK_LOW, CDR_LOCK_HIGH, CDR_BYPASS, CDR_LOCK_HIGH};
		tx_tab = '{CDR_LOCK_LOW, CDR_BYPASS, CDR_BYPASS, CDR_LOCK_HIGH};
		bad_pages = '{8'h02, 8'h03, 8'h20, 8'h27, 8'h80, 8'hFF};
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		rd_chk(OFS_PAGE, 8'h00);
		rd_chk(OFS_EXT, 8'h00);
		rd_chk(OFS_EXT2, 8'h00);
		rd_chk(OFS_RX_RATE, 8'h00);
		for (int c = 0; c < 16; c++) begin
			put_byte(OFS_EQ, {4'h7, 4'(c)});
			put_byte(OFS_EMPH, {4'h5, 4'(c)});
			wait_out(3);
			check({4'h0, eq_db}, (c <= 10) ? 8'(c) : 8'h00);
			check({7'h00, eq_bad}, {7'h00, c > 10});
			check({5'h00, emph_db}, (c < 8) ? 8'(c) : 8'h00);
			check({7'h00, emph_vendor}, {7'h00, c > 7});
		end
		rd_chk(OFS_EQ, 8'h7F);
		put_byte(OFS_EXT, 8'hFF);
		rd_chk(OFS_EXT, 8'h08);
		wait_out(3);
		check({7'h00, tx_full}, 8'h01);
		check({4'h0, eq_db}, 8'h07);
		put_byte(OFS_RX_RATE, 8'hFF);
		rd_chk(OFS_RX_RATE, 8'h08);
		wait_out(3);
		check({7'h00, rx_full}, 8'h01);
		check({5'h00, emph_db}, 8'h05);
		put_byte(OFS_EXT, 8'h00);
		put_byte(OFS_RX_RATE, 8'h00);
		@(posedge clk);
		tx_line <= 1'b1;
		rx_line <= 1'b1;
		wait_out(8);
		check({7'h00, tx_full}, 8'h01);
		check({7'h00, rx_full}, 8'h01);
		rd_chk(OFS_EXT, 8'h00);
		put_byte(OFS_EXT2, 8'hFF);
		rd_chk(OFS_EXT2, 8'h04);
		wait_out(3);
		check({6'h00, tx_full, rx_full}, 8'h00);
		check({7'h00, fc64}, 8'h01);
		check({4'h0, tx_mode, rx_mode}, {4'h0, CDR_LOCK_HIGH, CDR_LOCK_HIGH});
		put_byte(OFS_EXT2, 8'h00);
		tx_line <= 1'b0;
		rx_line <= 1'b0;
		adapt_fail <= 1'b1;
		tx_ready <= 1'b1;
		rx_lost <= 1'b1;
		wait_out(8);
		rd_chk(OFS_EXT, 8'h10);
		rd_chk(OFS_EXT2, 8'h11);
		@(posedge clk);
		adapt_fail <= 1'b0;
		tx_ready <= 1'b0;
		rx_ready <= 1'b1;
		tx_lost <= 1'b1;
		rx_lost <= 1'b0;
		put_byte(OFS_EXT2, 8'h1B);
		rd_chk(OFS_EXT2, 8'h0A);
		@(posedge clk);
		rx_ready <= 1'b0;
		tx_lost <= 1'b0;
		mid_impl <= 1'b1;
		put_byte(OFS_EXT, 8'h01);
		wait_out(3);
		rd_chk(OFS_EXT, 8'h03);
		check({7'h00, pl_mid}, 8'h01);
		@(posedge clk);
		level4_adv <= 1'b1;
		put_byte(OFS_EXT, 8'h04);
		wait_out(3);
		rd_chk(OFS_EXT, 8'h04);
		check({7'h00, pl_high}, 8'h01);
		@(posedge clk);
		steady <= 1'b1;
		temp_ok <= 1'b1;
		laser_off <= 1'b1;
		wait_out(8);
		rd_chk(OFS_EXT, 8'h06);
		@(posedge clk);
		laser_off <= 1'b0;
		wait_out(8);
		rd_chk(OFS_EXT, 8'h04);
		@(posedge clk);
		optical <= 1'b1;
		wait_out(3);
		rd_chk(OFS_EXT, 8'h06);
		put_byte(OFS_USER_LO, 8'hA5);
		put_byte(OFS_USER_HI, 8'h5A);
		put_byte(OFS_VMEM_LO, 8'h3C);
		put_byte(OFS_VMEM_HI, 8'hC3);
		put_byte(OFS_VCTRL_LO, 8'h96);
		put_byte(8'hFF, 8'h69);
		rd_chk(OFS_USER_LO, 8'hA5);
		rd_chk(OFS_USER_HI, 8'h5A);
		rd_chk(OFS_VMEM_LO, 8'h3C);
		rd_chk(OFS_VMEM_HI, 8'hC3);
		rd_chk(OFS_VCTRL_LO, 8'h96);
		rd_chk(8'hFF, 8'h69);
		wait_out(1);
		check(rdata, 8'h00);
		rd_chk(8'h70, 8'h00);
		put_byte(OFS_PAGE, 8'h01);
		rd_chk(OFS_PAGE, 8'h01);
		rd_chk(OFS_USER_LO, 8'hA5);
		put_byte(8'h81, 8'h77);
		rd_chk(OFS_VCTRL_LO, 8'h96);
		foreach (bad_pages[k]) begin
			put_byte(OFS_PAGE, 8'h01);
			put_byte(OFS_PAGE, bad_pages[k]);
			rd_chk(OFS_PAGE, 8'h00);
		end
		rd_chk(8'h81, 8'h77);
		@(posedge clk);
		ident <= ID_RETIMER;
		cdr_present <= 1'b1;
		tx_lost <= 1'b1;
		rx_lost <= 1'b1;
		rst_n <= 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		rd_chk(OFS_EXT, 8'h08);
		rd_chk(OFS_RX_RATE, 8'h08);
		rd_chk(OFS_PAGE, 8'h00);
		for (int i = 0; i < 4; i++) begin
			put_byte(OFS_RX_RATE, {4'h0, i[1], 3'h0});
			put_byte(OFS_EXT, {4'h0, i[0], 3'h0});
			wait_out(3);
			check({6'h00, rx_mode}, {6'h00, rx_tab[i]});
			check({6'h00, tx_mode}, {6'h00, tx_tab[i]});
			rd_chk(OFS_EXT2, {6'h00, tx_tab[i] != CDR_BYPASS, rx_tab[i] != CDR_BYPASS});
		end
		test_done();
	end
endmodule
